// ---- hw/flash_op_timer.sv ----
// Self-timed operation counter for program and erase
`timescale 1ns/1ns
`default_nettype none
module flash_op_timer #(
    parameter int unsigned W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    flash_timer_if.timer tmr
);
    logic [W-1:0] remain_ff;
    logic run_ff;
    logic expired_ff;

    // Expiry pulses exactly count cycles after the load edge
    wire last_tick = run_ff && (remain_ff == W'(1));

    // Down counter, cancel stops it without an expiry pulse
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            remain_ff <= '0;
            run_ff <= 1'b0;
            expired_ff <= 1'b0;
        end else begin
            expired_ff <= 1'b0;
            if (tmr.load) begin
                remain_ff <= tmr.count;
                run_ff <= 1'b1;
            end else if (tmr.cancel) begin
                run_ff <= 1'b0;
            end else if (run_ff) begin
                remain_ff <= remain_ff - W'(1);
                run_ff <= !last_tick;
                expired_ff <= last_tick;
            end
        end
    end

    assign tmr.expired = expired_ff;
endmodule
`default_nettype wire

// ---- hw/flash_operation_control.sv ----
// Flash program/erase sequencer with control, event and mask registers
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Setting the start bit launches the chosen operation, which runs self-timed and hardware clears the bit at the end; software cannot clear it.
// - The enable bit gates all flash activity; with it at zero a start request drives no flash strobe but sets the sequence error flag.
// - An improper start attempt or an improper end of an operation sets the sequence error flag.
// - An operation that ends normally leaves the sequence error flag as it was; a launch, or a control write with that bit at zero, clears it.
// - The four-bit operation select field decides which operation a start request performs.
// - Code 0011 erases one memory page.
// - Code 0001 programs a double word.
module flash_operation_control #(
    parameter int unsigned ERASE_CYCLES_P = flash_seq_pkg::ERASE_CYCLES,
    parameter int unsigned PROG_CYCLES_P = flash_seq_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [flash_seq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [flash_seq_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    output logic flash_page_erase,
    output logic flash_dword_prog,
    output logic idle_regulator_standby
);
    import flash_seq_pkg::*;

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    seq_state_t state_ff, nxt_state;
    logic start_ff, nxt_start;
    logic op_enable_ff;
    logic sequence_error_ff, nxt_sequence_error;
    logic standby_ff;
    logic [OPSEL_W-1:0] operation_select_ff;
    logic [EVT_W-1:0] status_ff, nxt_status;
    logic [EVT_W-1:0] mask_ff, nxt_mask;
    logic [DATA_W-1:0] rdata_ff;
    logic irq_ff;
    logic erase_out_ff;
    logic prog_out_ff;

    flash_timer_if #(.W(TIMER_W)) tmr_if ();

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == OFS_CONTROL);
    wire wr_status = reg_wr && (reg_addr == OFS_EVENT_STATUS);
    wire wr_mask = reg_wr && (reg_addr == OFS_EVENT_MASK);
    wire busy = (state_ff != ST_IDLE);
    wire [OPSEL_W-1:0] req_opsel = reg_wdata[OPSEL_MSB:OPSEL_LSB];
    wire req_enable = reg_wdata[BIT_OP_ENABLE];

    // Start request decode: enable gate and operation code
    wire start_req = wr_ctrl && reg_wdata[BIT_START];
    wire code_erase = (req_opsel == OPSEL_PAGE_ERASE);
    wire code_prog = (req_opsel == OPSEL_DWORD_PROG);
    wire launch_erase = start_req && !busy && req_enable && code_erase;
    wire launch_prog = start_req && !busy && req_enable && code_prog;
    wire launch = launch_erase || launch_prog;
    // Start while busy, while disabled or with a reserved code is refused
    wire bad_start = start_req && !launch;
    // Dropping the enable in mid-operation terminates it improperly
    wire abort = busy && wr_ctrl && !req_enable;
    wire done = busy && tmr_if.expired && !abort;
    wire err_event = bad_start || abort;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (launch_erase) begin
                    nxt_state = ST_ERASE;
                end else if (launch_prog) begin
                    nxt_state = ST_PROG;
                end
            end
            ST_ERASE, ST_PROG: begin
                if (done || abort) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Start bit: set only by a launch, cleared only by hardware
    assign nxt_start = launch ? 1'b1 : ((done || abort) ? 1'b0 : start_ff);

    // Error flag: hardware set wins, a clean launch clears it
    always_comb begin
        nxt_sequence_error = sequence_error_ff;
        if (err_event) begin
            nxt_sequence_error = 1'b1;
        end else if (launch) begin
            nxt_sequence_error = 1'b0;
        end else if (wr_ctrl) begin
            nxt_sequence_error = reg_wdata[BIT_SEQUENCE_ERROR];
        end
    end

    // Events set sticky bits; a written one clears, set wins
    assign nxt_status = (status_ff & ~(wr_status ? reg_wdata[EVT_W-1:0] : EVENT_RST))
        | {err_event, done};
    assign nxt_mask = wr_mask ? reg_wdata[EVT_W-1:0] : mask_ff;

    // ------------------------------------------------------------
    // Timer link
    // ------------------------------------------------------------
    assign tmr_if.load = launch;
    assign tmr_if.count = launch_erase ? TIMER_W'(ERASE_CYCLES_P) : TIMER_W'(PROG_CYCLES_P);
    assign tmr_if.cancel = abort;

    flash_op_timer #(.W(TIMER_W)) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tmr(tmr_if)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [DATA_W-1:0] ctrl_view = {start_ff, op_enable_ff, sequence_error_ff, standby_ff,
        8'h00, operation_select_ff};
    wire [DATA_W-1:0] rd_mux =
        (reg_addr == OFS_CONTROL) ? ctrl_view :
        (reg_addr == OFS_EVENT_STATUS) ? {14'h0000, status_ff} :
        (reg_addr == OFS_EVENT_MASK) ? {14'h0000, mask_ff} : RDATA_RST;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            start_ff <= CONTROL_RST[BIT_START];
            sequence_error_ff <= CONTROL_RST[BIT_SEQUENCE_ERROR];
            status_ff <= EVENT_RST;
            mask_ff <= EVENT_RST;
        end else begin
            state_ff <= nxt_state;
            start_ff <= nxt_start;
            sequence_error_ff <= nxt_sequence_error;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
        end
    end

    // Control fields; the operation code is frozen while busy
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_enable_ff <= CONTROL_RST[BIT_OP_ENABLE];
            standby_ff <= CONTROL_RST[BIT_IDLE_STANDBY];
            operation_select_ff <= CONTROL_RST[OPSEL_MSB:OPSEL_LSB];
        end else if (wr_ctrl) begin
            op_enable_ff <= req_enable;
            standby_ff <= reg_wdata[BIT_IDLE_STANDBY];
            if (!busy) begin
                operation_select_ff <= req_opsel;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= RDATA_RST;
            irq_ff <= 1'b0;
            erase_out_ff <= 1'b0;
            prog_out_ff <= 1'b0;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : RDATA_RST;
            irq_ff <= |(nxt_status & nxt_mask);
            erase_out_ff <= (nxt_state == ST_ERASE);
            prog_out_ff <= (nxt_state == ST_PROG);
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq = irq_ff;
    assign flash_page_erase = erase_out_ff;
    assign flash_dword_prog = prog_out_ff;
    assign idle_regulator_standby = standby_ff;

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] busy_len_ff, nxt_busy_len;

    // Cycles since the launch edge, held once the sequencer is idle
    assign nxt_busy_len = launch ? '0 : (busy_len_ff + TIMER_W'(busy));

    // Helper counter, only the checks below read it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_ff <= '0;
        end else begin
            busy_len_ff <= nxt_busy_len;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Start bit: set by a launch, held by hardware, cleared at the end
    a_launch_sets_start: assert property (launch |=> start_ff && busy)
        else $error("start bit not set after launch");
    a_end_clears_start: assert property (done |=> !start_ff && !busy)
        else $error("start bit still set after completion");
    a_start_held: assert property (start_ff && !done && !abort |=> start_ff)
        else $error("start bit dropped before the end");
    a_start_set_only: assert property (!start_ff && !launch |=> !start_ff)
        else $error("start bit set without a launch");
    a_done_event: assert property (done |=> status_ff[EVT_DONE])
        else $error("completion event not recorded");
    a_timer_quiet: assert property (!busy |-> !tmr_if.expired)
        else $error("timer expired while idle");

    // Enable gate
    a_disabled_no_op: assert property (start_req && !req_enable && !busy
        |=> !flash_page_erase && !flash_dword_prog && sequence_error_ff)
        else $error("disabled start reached the flash");
    a_enable_gate: assert property ((flash_page_erase || flash_dword_prog) |-> op_enable_ff)
        else $error("flash activity without enable");

    // Improper sequences and clean ends
    a_abort_flags_error: assert property (abort |=> sequence_error_ff && !busy
        && !flash_page_erase && !flash_dword_prog)
        else $error("improper termination not flagged");
    a_error_flagged: assert property (bad_start |=> sequence_error_ff && status_ff[EVT_ERROR])
        else $error("refused start not flagged");
    a_clean_end_ok: assert property (done && !wr_ctrl && !sequence_error_ff
        |=> !sequence_error_ff)
        else $error("error flag set after normal completion");
    a_launch_clears: assert property (launch |=> !sequence_error_ff)
        else $error("error flag not cleared at launch");
    a_error_write: assert property (wr_ctrl && !err_event && !launch
        |=> sequence_error_ff == $past(reg_wdata[BIT_SEQUENCE_ERROR]))
        else $error("error flag write not taken");

    // Operation code decode
    a_code_decode: assert property (flash_page_erase |-> operation_select_ff == OPSEL_PAGE_ERASE
        && !flash_dword_prog)
        else $error("erase output without erase code");
    a_prog_decode: assert property (flash_dword_prog |-> operation_select_ff == OPSEL_DWORD_PROG)
        else $error("program output without program code");
    a_one_strobe: assert property (!(flash_page_erase && flash_dword_prog))
        else $error("erase and program both active");
    a_opsel_frozen: assert property (busy && wr_ctrl |=> $stable(operation_select_ff))
        else $error("operation code changed while busy");

    // Operation lengths against the helper counter
    a_erase_holds: assert property (flash_page_erase && !done && !abort |=> flash_page_erase)
        else $error("page erase did not hold");
    a_erase_length: assert property (done && state_ff == ST_ERASE
        |-> busy_len_ff == TIMER_W'(ERASE_CYCLES_P))
        else $error("page erase ended at the wrong time");
    a_prog_runs: assert property (launch_prog |=> flash_dword_prog && !flash_page_erase)
        else $error("double-word program not started");
    a_prog_length: assert property (done && state_ff == ST_PROG
        |-> busy_len_ff == TIMER_W'(PROG_CYCLES_P))
        else $error("double-word program ended at the wrong time");

    // Reserved codes and refused starts
    a_reserved_code: assert property (start_req && !busy && req_enable && !code_erase
        && !code_prog |=> !busy && sequence_error_ff && !start_ff)
        else $error("reserved code altered the flash");
    a_no_op_on_bad: assert property (bad_start && !busy |=> !flash_page_erase && !flash_dword_prog)
        else $error("refused start reached the flash");

    // Register port and interrupt
    a_irq_level: assert property (##1 irq == |(status_ff & mask_ff))
        else $error("interrupt output does not follow status and mask");
    a_status_sticky: assert property (status_ff[EVT_DONE]
        && !(wr_status && reg_wdata[EVT_DONE]) |=> status_ff[EVT_DONE])
        else $error("done event lost without a clear");
    a_mask_write: assert property (wr_mask |=> mask_ff == $past(reg_wdata[EVT_W-1:0]))
        else $error("mask write not taken");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == RDATA_RST)
        else $error("read data shown without a read");
    a_standby_copy: assert property (wr_ctrl
        |=> idle_regulator_standby == $past(reg_wdata[BIT_IDLE_STANDBY]))
        else $error("standby bit write not taken");

    // Main scenarios
    c_erase_done: cover property (done && state_ff == ST_ERASE);
    c_prog_done: cover property (done && state_ff == ST_PROG);
    c_abort: cover property (busy && abort);
    c_bad_start: cover property (bad_start);
    c_reserved_code: cover property (start_req && !busy && req_enable && !code_erase && !code_prog);
endmodule
`default_nettype wire

// ---- hw/flash_seq_pkg.sv ----
// Shared constants and types for the flash program/erase sequencer
package flash_seq_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_EVENT_STATUS = 4'h1;
    localparam logic [3:0] OFS_EVENT_MASK = 4'h2;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_START = 15;
    localparam int unsigned BIT_OP_ENABLE = 14;
    localparam int unsigned BIT_SEQUENCE_ERROR = 13;
    localparam int unsigned BIT_IDLE_STANDBY = 12;
    localparam int unsigned OPSEL_MSB = 3;
    localparam int unsigned OPSEL_LSB = 0;
    localparam int unsigned OPSEL_W = 4;

    // Operation select codes
    localparam logic [3:0] OPSEL_PAGE_ERASE = 4'h3;
    localparam logic [3:0] OPSEL_DWORD_PROG = 4'h1;

    // ------------------------------------------------------------
    // Event bits and reset values
    // ------------------------------------------------------------
    localparam int unsigned EVT_DONE = 0;
    localparam int unsigned EVT_ERROR = 1;
    localparam int unsigned EVT_W = 2;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [1:0] EVENT_RST = 2'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned ERASE_TIME_NS = 20000;
    localparam int unsigned PROG_TIME_NS = 1000;
    localparam int unsigned TIMER_W = 16;
    // Least times round up to whole cycles
    localparam int unsigned ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG = 3'b100
    } seq_state_t;

endpackage

// ---- hw/flash_timer_if.sv ----
// Link between the sequencer and its operation timer
`timescale 1ns/1ns
`default_nettype none
interface flash_timer_if #(parameter int unsigned W = 16);
    logic load;
    logic [W-1:0] count;
    logic cancel;
    logic expired;

    modport seq (output load, output count, output cancel, input expired);
    modport timer (input load, input count, input cancel, output expired);
endinterface
`default_nettype wire

// ---- verif/flash_array_model.sv ----
// Behavioural flash array that counts and times program and erase strobes
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic flash_page_erase,
    input wire logic flash_dword_prog,
    output int erase_count,
    output int prog_count,
    output int last_len
);
    int run_len;

    // ------------------------------------------------------------
    // Strobe timing
    // ------------------------------------------------------------
    // Count each operation at its first cycle, keep its length once it ends
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            erase_count <= 0;
            prog_count <= 0;
            last_len <= 0;
            run_len <= 0;
        end else begin
            if (flash_page_erase || flash_dword_prog) begin
                run_len <= run_len + 1;
            end else begin
                run_len <= 0;
            end
            if (run_len == 0 && flash_page_erase) begin
                erase_count <= erase_count + 1;
            end
            if (run_len == 0 && flash_dword_prog) begin
                prog_count <= prog_count + 1;
            end
            if (run_len != 0 && !flash_page_erase && !flash_dword_prog) begin
                last_len <= run_len;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/flash_operation_control_tb.sv ----
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_operation_control_tb;
    import flash_seq_pkg::*;
    localparam int unsigned ERASE_N = 10;
    localparam int unsigned PROG_N = 3;
    logic clk_sys, rst_b, reg_wr, reg_rd, l;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, w, seed;
    logic irq, flash_page_erase, flash_dword_prog, idle_regulator_standby;
    int err_count, n_tests, erase_count, prog_count, last_len, e0, p0;

    flash_operation_control #(.ERASE_CYCLES_P(ERASE_N), .PROG_CYCLES_P(PROG_N)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .flash_page_erase(flash_page_erase), .flash_dword_prog(flash_dword_prog),
        .idle_regulator_standby(idle_regulator_standby));
    flash_array_model flash (
        .clk_sys(clk_sys), .rst_b(rst_b), .flash_page_erase(flash_page_erase),
        .flash_dword_prog(flash_dword_prog), .erase_count(erase_count),
        .prog_count(prog_count), .last_len(last_len));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // A start runs only with enable set and a defined operation code
    function automatic logic launches(input logic [15:0] d);
        return d[BIT_START] && d[BIT_OP_ENABLE]
            && (d[3:0] == OPSEL_PAGE_ERASE || d[3:0] == OPSEL_DWORD_PROG);
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait for both strobes to fall, then let the model record the length
    task automatic wait_idle;
        for (int k = 0; k < 4000 && (flash_page_erase !== 1'h0 || flash_dword_prog !== 1'h0); k++) begin
            settle();
        end
        chk("strobes idle", 16'h0, {14'h0, flash_page_erase, flash_dword_prog});
        settle();
    endtask
    task automatic report_and_stop;
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #(8 * 20000);
        err_count++;
        report_and_stop();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        seed = 16'h0007;
        err_count = 0;
        n_tests = 0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'h1;
        // Reset contents, unmapped index reads zero
        for (int i = 0; i < 4; i++) begin
            rd((i == 3) ? 4'hf : i[3:0]);
            chk("reset read", 16'h0, rd_val);
        end
        $display("test reset done");
        // Erase with a clear attempt and a second start while busy
        e0 = erase_count;
        wr(OFS_CONTROL, 16'hc003);
        chk("erase active", 16'h1, flash_page_erase);
        rd(OFS_CONTROL);
        chk("start reads busy", 16'h1, rd_val[BIT_START]);
        wr(OFS_CONTROL, 16'h4003);
        chk("start not cleared", 16'h1, flash_page_erase);
        wr(OFS_CONTROL, 16'hc001);
        chk("busy start refused", 16'h0, flash_dword_prog);
        wait_idle();
        chk("erase length", 16'h1, last_len >= ERASE_N);
        chk("erase count", e0 + 1, erase_count);
        rd(OFS_CONTROL);
        chk("busy start error", 16'h1, rd_val[BIT_SEQUENCE_ERROR]);
        rd(OFS_EVENT_STATUS);
        chk("status after busy start", 16'h3, rd_val);
        wr(OFS_EVENT_STATUS, 16'h0003);
        $display("test busy done");
        // Abort by dropping enable mid-operation
        wr(OFS_CONTROL, 16'hc003);
        wr(OFS_CONTROL, 16'h0003);
        settle();
        chk("abort drops", 16'h0, flash_page_erase);
        wait_idle();
        rd(OFS_EVENT_STATUS);
        chk("abort status", 16'h2, rd_val);
        wr(OFS_EVENT_STATUS, 16'h0003);
        $display("test abort done");
        // Every code swept twice; enable (forced high in the second pass) and standby bit drawn at random
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            w = {1'h1, seed[0] | i[4], 1'h0, seed[12], seed[11:4], i[3:0]};
            l = launches(w);
            e0 = erase_count;
            p0 = prog_count;
            wr(OFS_CONTROL, w);
            chk("erase strobe", l && w[3:0] == OPSEL_PAGE_ERASE, flash_page_erase);
            chk("prog strobe", l && w[3:0] == OPSEL_DWORD_PROG, flash_dword_prog);
            wait_idle();
            chk("erase count", e0 + (l && w[3:0] == 4'h3), erase_count);
            chk("prog count", p0 + (l && w[3:0] == 4'h1), prog_count);
            if (l) begin
                chk("op length", 16'h1, last_len >= (w[1] ? ERASE_N : PROG_N));
            end
            rd(OFS_CONTROL);
            chk("control", {1'h0, w[14], !l, w[12], 8'h00, w[3:0]}, rd_val);
            chk("standby", w[12], idle_regulator_standby);
            rd(OFS_EVENT_STATUS);
            chk("status", {14'h0, !l, l}, rd_val);
            wr(OFS_EVENT_STATUS, 16'h0003);
        end
        $display("test random done");
        // Interrupt raised, masked and cleared
        wr(OFS_CONTROL, 16'h8001);
        settle();
        chk("irq masked", 16'h0, irq);
        wr(OFS_EVENT_MASK, 16'h0002);
        settle();
        chk("irq raised", 16'h1, irq);
        wr(OFS_EVENT_STATUS, 16'h0002);
        settle();
        chk("irq cleared", 16'h0, irq);
        rd(OFS_EVENT_MASK);
        chk("mask readback", 16'h2, rd_val);
        $display("test irq done");
        report_and_stop();
    end
endmodule
`default_nettype wire
